// [common/sldrv_map.vh]
// Operation
// - no frontplane waveform while display disabled
// - enabled display drives frontplane once enable set
// - only five duty and bias combinations exist
// - duty field 01,10,11,00 gives 1/1..1/4
// - bias bit matters only at half duty
// - unused backplanes stay high impedance
// - backplane waveform fixed, independent of memory
// - frontplane waveform built from segment memory
// - logic picks one of four levels
// - halt bit clear keeps waveforms in wait
// - halt in wait parks enabled pins low
// - memory and registers kept across wait
// - stop halts clocks, parks pins, keeps state
// - leaving stop resumes with prior pin function
// - slow oscillator enable clears only at reset
// - block raises no interrupt request
// - reset gives quarter duty, third bias, outputs off
// - prescaler divides source by 64 to 512
// - segment bit one drives on when enabled
`ifndef SLDRV_MAP_VH
`define SLDRV_MAP_VH

// register byte addresses
`define SLD_ADR_CTRL0 8'h00
`define SLD_ADR_CTRL1 8'h04
`define SLD_ADR_FPEN_LO 8'h08
`define SLD_ADR_FPEN_HI 8'h0c
`define SLD_ADR_SEG_FIRST 8'h10
`define SLD_ADR_SEG_LAST 8'h20
`define SLD_ADR_STATUS 8'h28
`define SLD_SEG_WORDS 5

// display_control_0 fields
`define SLD_C0_DUTY_LO 0
`define SLD_C0_DUTY_HI 1
`define SLD_C0_BIAS 2
`define SLD_C0_PRE_LO 4
`define SLD_C0_PRE_HI 5
`define SLD_C0_GEN 7
`define SLD_C0_RESET 32'h00000004

// display_control_1 fields
`define SLD_C1_HALT_WAIT 0
`define SLD_C1_SLOW_OSC 1

// duty codes
`define SLD_DUTY_1_1 2'h1
`define SLD_DUTY_1_2 2'h2
`define SLD_DUTY_1_3 2'h3
`define SLD_DUTY_1_4 2'h0

// bias mode codes towards the level generator
`define SLD_BIAS_1_1 2'h0
`define SLD_BIAS_1_2 2'h1
`define SLD_BIAS_1_3 2'h2

// prescaler divide ratios
`define SLD_DIV_00 10'h040
`define SLD_DIV_01 10'h080
`define SLD_DIV_10 10'h100
`define SLD_DIV_11 10'h200

// level select codes, V0 is driver_ground, V3 is panel_supply
`define SLD_LVL_V0 2'h0
`define SLD_LVL_V1 2'h1
`define SLD_LVL_V2 2'h2
`define SLD_LVL_V3 2'h3

`endif

// [hdl/sldrv_prescale.v]
`timescale 1ns/1ps
`default_nettype none
`include "sldrv_map.vh"

module sldrv_prescale (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire run,
  input wire src_tick,
  input wire [1:0] sel,
  // display clock event
  output reg tick
);

  reg [9:0] cnt;
  reg [9:0] div;

  always @* begin
    case (sel)
      2'h0: div = `SLD_DIV_00;
      2'h1: div = `SLD_DIV_01;
      2'h2: div = `SLD_DIV_10;
      default: div = `SLD_DIV_11;
    endcase
  end

  // counting freezes while not running, so a halt resumes mid-period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 10'h000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (run && src_tick) begin
        if (cnt >= div - 10'h001) begin
          cnt <= 10'h000;
          tick <= 1'b1;
        end else begin
          cnt <= cnt + 10'h001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [hdl/sldrv_fpmux.v]
`timescale 1ns/1ps
`default_nettype none
`include "sldrv_map.vh"

module sldrv_fpmux (
  // segment data of this frontplane, one bit per backplane
  input wire [3:0] seg,
  // sequencing
  input wire [1:0] slot,
  input wire pol,
  input wire drive,
  input wire park,
  // pin
  output reg [1:0] level,
  output wire oe
);

  assign oe = drive;

  // on: opposite extreme to the selected backplane; off: inner level
  always @* begin
    if (!drive || park) begin
      level = `SLD_LVL_V0;
    end else if (seg[slot]) begin
      level = pol ? `SLD_LVL_V3 : `SLD_LVL_V0;
    end else begin
      level = pol ? `SLD_LVL_V1 : `SLD_LVL_V2;
    end
  end

endmodule
`default_nettype wire

// [hdl/sldrv_top.v]
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "sldrv_map.vh"

module sldrv_top (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // wishbone slave
  input wire WB_CYC,
  input wire WB_STB,
  input wire WB_WE,
  input wire [7:0] WB_ADR,
  input wire [3:0] WB_SEL,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK,
  // system state and source clock event
  input wire SRC_TICK,
  input wire WAIT_MODE,
  input wire STOP_MODE,
  // clock power unit
  output reg SLOW_OSC_EN,
  // interrupt line, never asserted
  output wire DISPLAY_IRQ,
  // frontplane_outputs
  output reg [79:0] FP_LEVEL,
  output reg [39:0] FP_OE,
  // backplane_outputs
  output reg [7:0] BP_LEVEL,
  output reg [3:0] BP_OE,
  // level generator mode
  output reg [1:0] BIAS_MODE
);

  // byte-lane merge, used by every writable register
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] sel;
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          wmerge[b*8 +: 8] = din[b*8 +: 8];
        end
      end
    end
  endfunction

  // active backplanes per duty
  function [2:0] bp_count;
    input [1:0] duty;
    begin
      case (duty)
        `SLD_DUTY_1_1: bp_count = 3'h1;
        `SLD_DUTY_1_2: bp_count = 3'h2;
        `SLD_DUTY_1_3: bp_count = 3'h3;
        default: bp_count = 3'h4;
      endcase
    end
  endfunction

  // addressable segments, forty per active backplane
  function [7:0] seg_count;
    input [2:0] nbp;
    begin
      case (nbp)
        3'h1: seg_count = 8'h28;
        3'h2: seg_count = 8'h50;
        3'h3: seg_count = 8'h78;
        default: seg_count = 8'ha0;
      endcase
    end
  endfunction

  // backplane level: extreme when selected, inner level otherwise
  function [1:0] bp_level;
    input selected;
    input pol;
    begin
      if (selected) begin
        bp_level = pol ? `SLD_LVL_V0 : `SLD_LVL_V3;
      end else begin
        bp_level = pol ? `SLD_LVL_V2 : `SLD_LVL_V1;
      end
    end
  endfunction

  // bias mode follows duty; the bias bit only counts at half duty
  function [1:0] bias_of;
    input [1:0] duty;
    input bias;
    begin
      case (duty)
        `SLD_DUTY_1_1: bias_of = `SLD_BIAS_1_1;
        `SLD_DUTY_1_2: bias_of = bias ? `SLD_BIAS_1_3 : `SLD_BIAS_1_2;
        default: bias_of = `SLD_BIAS_1_3;
      endcase
    end
  endfunction

  // control registers
  reg [1:0] duty;
  reg bias;
  reg [1:0] presc;
  reg gen;
  reg halt_wait;
  reg [39:0] fpen;
  reg [31:0] seg_mem [0:`SLD_SEG_WORDS-1];

  // engine state
  reg [1:0] slot;
  reg pol;

  wire req;
  wire wr;
  wire seg_hit;
  wire [3:0] seg_off;
  wire [31:0] ctrl0_word;
  wire [31:0] ctrl1_word;
  wire [31:0] status_word;
  wire [31:0] next_ctrl0;
  wire [31:0] next_ctrl1;
  wire [2:0] nbp;
  wire halted;
  wire run;
  wire disp_tick;
  wire [159:0] seg_flat;
  wire [79:0] next_fp_level;
  wire [39:0] next_fp_oe;
  wire [31:0] next_fpen_hi;
  wire last_slot;
  wire duty_changed;
  reg [1:0] duty_q;
  reg [31:0] next_rdata;
  reg [7:0] next_bp_level;
  reg [3:0] next_bp_oe;
  integer k;
  integer j;

  assign DISPLAY_IRQ = 1'b0;

  // ---- bus slave
  assign req = WB_CYC & WB_STB;
  // write lands on the edge at which the master samples ack
  assign wr = req & WB_WE & WB_ACK;
  assign seg_off = WB_ADR[5:2] - 4'h4;
  assign seg_hit = (WB_ADR >= `SLD_ADR_SEG_FIRST) && (WB_ADR <= `SLD_ADR_SEG_LAST) &&
                   (WB_ADR[1:0] == 2'h0);

  assign ctrl0_word = {24'h000000, gen, 1'b0, presc, 1'b0, bias, duty};
  assign ctrl1_word = {30'h00000000, SLOW_OSC_EN, halt_wait};
  assign status_word = {15'h0000, run, seg_count(nbp), 1'b0, nbp, halted, pol, slot};
  assign next_ctrl0 = wmerge(ctrl0_word, WB_DAT_I, WB_SEL);
  assign next_ctrl1 = wmerge(ctrl1_word, WB_DAT_I, WB_SEL);
  assign next_fpen_hi = wmerge({24'h000000, fpen[39:32]}, WB_DAT_I, WB_SEL);

  always @* begin
    next_rdata = 32'h00000000;
    if (seg_hit) begin
      next_rdata = seg_mem[seg_off[2:0]];
    end else begin
      case (WB_ADR)
        `SLD_ADR_CTRL0: next_rdata = ctrl0_word;
        `SLD_ADR_CTRL1: next_rdata = ctrl1_word;
        `SLD_ADR_FPEN_LO: next_rdata = fpen[31:0];
        `SLD_ADR_FPEN_HI: next_rdata = {24'h000000, fpen[39:32]};
        `SLD_ADR_STATUS: next_rdata = status_word;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // one-cycle answer, every address acknowledged; unmapped reads zero
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK <= req & ~WB_ACK;
      if (req && !WB_ACK) begin
        WB_DAT_O <= next_rdata;
      end
    end
  end

  // register file; low-power modes never touch it
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      duty <= `SLD_DUTY_1_4;
      bias <= 1'b1;
      presc <= 2'h0;
      gen <= 1'b0;
      halt_wait <= 1'b0;
      SLOW_OSC_EN <= 1'b0;
      fpen <= 40'h0000000000;
      for (k = 0; k < `SLD_SEG_WORDS; k = k + 1) begin
        seg_mem[k] <= 32'h00000000;
      end
    end else if (wr) begin
      if (seg_hit) begin
        seg_mem[seg_off[2:0]] <= wmerge(seg_mem[seg_off[2:0]], WB_DAT_I, WB_SEL);
      end else begin
        case (WB_ADR)
          `SLD_ADR_CTRL0: begin
            duty <= {next_ctrl0[`SLD_C0_DUTY_HI], next_ctrl0[`SLD_C0_DUTY_LO]};
            bias <= next_ctrl0[`SLD_C0_BIAS];
            presc <= {next_ctrl0[`SLD_C0_PRE_HI], next_ctrl0[`SLD_C0_PRE_LO]};
            gen <= next_ctrl0[`SLD_C0_GEN];
          end
          `SLD_ADR_CTRL1: begin
            halt_wait <= next_ctrl1[`SLD_C1_HALT_WAIT];
            // sticky: software can start it but never stop it
            SLOW_OSC_EN <= SLOW_OSC_EN | next_ctrl1[`SLD_C1_SLOW_OSC];
          end
          `SLD_ADR_FPEN_LO: fpen[31:0] <= wmerge(fpen[31:0], WB_DAT_I, WB_SEL);
          `SLD_ADR_FPEN_HI: begin
            fpen[39:32] <= next_fpen_hi[7:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ---- waveform engine
  assign nbp = bp_count(duty);
  assign halted = STOP_MODE | (WAIT_MODE & halt_wait);
  assign run = gen & ~halted;
  assign last_slot = ({1'b0, slot} >= nbp - 3'h1);
  assign duty_changed = (duty != duty_q);

  // a new duty restarts the frame at backplane 0; otherwise a shrinking
  // backplane count could leave the slot pointing at an idle plane
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      duty_q <= `SLD_DUTY_1_4;
    end else begin
      duty_q <= duty;
    end
  end

  sldrv_prescale u_prescale (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .run(run),
    .src_tick(SRC_TICK),
    .sel(presc),
    .tick(disp_tick)
  );

  // slot walks 0..nbp-1, polarity flips at each frame end; a halt freezes
  // both so the waveform picks up where it stopped
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      slot <= 2'h0;
      pol <= 1'b0;
    end else if (!gen) begin
      slot <= 2'h0;
      pol <= 1'b0;
    end else if (duty_changed) begin
      slot <= 2'h0;
    end else if (disp_tick) begin
      if (last_slot) begin
        slot <= 2'h0;
        pol <= ~pol;
      end else begin
        slot <= slot + 2'h1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SLD_SEG_WORDS; g = g + 1) begin : g_flat
      assign seg_flat[g*32 +: 32] = seg_mem[g];
    end
    for (g = 0; g < 40; g = g + 1) begin : g_fp
      sldrv_fpmux u_fp (
        .seg(seg_flat[g*4 +: 4]),
        .slot(slot),
        .pol(pol),
        .drive(gen & fpen[g]),
        .park(halted),
        .level(next_fp_level[g*2 +: 2]),
        .oe(next_fp_oe[g])
      );
    end
  endgenerate

  // backplanes depend on mode, slot and polarity only, never on segment memory;
  // parked and idle planes sit at ground level
  always @* begin
    next_bp_level = 8'h00;
    next_bp_oe = 4'h0;
    for (j = 0; j < 4; j = j + 1) begin
      next_bp_oe[j] = gen & (j < nbp);
      if (!halted && gen && (j < nbp)) begin
        next_bp_level[j*2 +: 2] = bp_level(slot == j, pol);
      end
    end
  end

  // pin stage registered; adds one cycle behind any control change
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FP_LEVEL <= 80'h0;
      FP_OE <= 40'h0;
      BP_LEVEL <= 8'h00;
      BP_OE <= 4'h0;
      BIAS_MODE <= `SLD_BIAS_1_3;
    end else begin
      FP_LEVEL <= next_fp_level;
      FP_OE <= next_fp_oe;
      BIAS_MODE <= bias_of(duty, bias);
      BP_LEVEL <= next_bp_level;
      BP_OE <= next_bp_oe;
    end
  end

endmodule
`default_nettype wire

// [sim/sldrv_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module sldrv_sva (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // bus
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_ACK,
  // state and pins
  input wire logic STOP_MODE,
  input wire logic SLOW_OSC_EN,
  input wire logic DISPLAY_IRQ,
  input wire logic [79:0] FP_LEVEL,
  input wire logic [39:0] FP_OE,
  input wire logic [7:0] BP_LEVEL,
  input wire logic [3:0] BP_OE,
  input wire logic [1:0] BIAS_MODE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  irq_quiet_a: assert property (DISPLAY_IRQ == 1'b0)
    else $error("interrupt line raised");
  ack_time_a: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
    else $error("bus answer late");
  ack_pulse_a: assert property (WB_ACK |=> !WB_ACK)
    else $error("ack wider than one cycle");
  bp_contig_a: assert property (BP_OE inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("backplane drive set not contiguous");
  bp_idle_a: assert property (!BP_OE[3] |-> BP_LEVEL[7:6] == 2'h0)
    else $error("idle backplane level not zero");
  fp_gated_a: assert property (|FP_OE |-> |BP_OE)
    else $error("frontplane driven while display off");
  stop_park_a: assert property (STOP_MODE ##1 STOP_MODE |-> FP_LEVEL == 80'h0 && BP_LEVEL == 8'h0)
    else $error("pins not parked in stop");
  stop_hold_a: assert property (STOP_MODE ##1 STOP_MODE |-> $stable(BP_OE) && $stable(FP_OE))
    else $error("pin function changed in stop");
  bias_one_a: assert property ((BP_OE == 4'h1) [*2] |-> BIAS_MODE == 2'h0)
    else $error("single plane bias wrong");
  bias_third_a: assert property ((BP_OE == 4'hf) [*2] |-> BIAS_MODE == 2'h2)
    else $error("quarter duty bias wrong");
  osc_sticky_a: assert property (SLOW_OSC_EN |=> SLOW_OSC_EN)
    else $error("slow oscillator dropped");
endmodule
bind sldrv_top sldrv_sva chk_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .WB_CYC(WB_CYC),
  .WB_STB(WB_STB), .WB_ACK(WB_ACK), .STOP_MODE(STOP_MODE), .SLOW_OSC_EN(SLOW_OSC_EN),
  .DISPLAY_IRQ(DISPLAY_IRQ), .FP_LEVEL(FP_LEVEL), .FP_OE(FP_OE), .BP_LEVEL(BP_LEVEL),
  .BP_OE(BP_OE), .BIAS_MODE(BIAS_MODE));
`default_nettype wire

// [sim/sldrv_panel.sv]
`timescale 1ns/1ps
`default_nettype none
module sldrv_panel (
  // pins
  input wire logic [79:0] fp_level,
  input wire logic [39:0] fp_oe,
  input wire logic [7:0] bp_level,
  input wire logic [3:0] bp_oe,
  // segments of frontplane 0
  output logic [3:0] seg_on
);
  // a segment only darkens under the full ground to supply swing
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      seg_on[b] = fp_oe[0] && bp_oe[b] && ({fp_level[1:0], bp_level[2*b +: 2]} inside {4'h3, 4'hc});
    end
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  reg clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, tick = 0, wt = 0, stp = 0;
  reg [7:0] adr = 8'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] dat = 32'h0, r, v;
  reg [39:0] f;
  reg [3:0] acc;
  wire [31:0] rdat;
  wire ack, osc, irq;
  wire [79:0] fpl;
  wire [39:0] fpo;
  wire [7:0] bpl;
  wire [3:0] bpo, seen;
  wire [1:0] bias;
  integer errors = 0, num_checks = 0, i, n;
  reg [31:0] eq[$], mq[$];
  always #4 clk = ~clk;
  sldrv_top dut_u (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK(ack),
    .SRC_TICK(tick), .WAIT_MODE(wt), .STOP_MODE(stp), .SLOW_OSC_EN(osc),
    .DISPLAY_IRQ(irq), .FP_LEVEL(fpl), .FP_OE(fpo), .BP_LEVEL(bpl), .BP_OE(bpo),
    .BIAS_MODE(bias));
  sldrv_panel panel_u (.fp_level(fpl), .fp_oe(fpo), .bp_level(bpl), .bp_oe(bpo),
    .seg_on(seen));
  task chk(input [159:0] s, input [159:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // a read notes its expected value and mask, the watcher compares at ack
  task wb(input [7:0] a, input w, input [31:0] d, input [31:0] m);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    if (!w) begin
      eq.push_back(d);
      mq.push_back(m);
    end
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task st(input integer k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1 && !we) begin
      chk(rdat & mq[0], eq[0] & mq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    r = $urandom(76);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    st(1);
    chk({osc, irq, bias, bpo, fpo}, {2'h0, 2'h2, 44'h0});
    wb(8'h00, 0, 32'h4, 32'hffffffff);
    wb(8'h30, 1, $urandom, 0);
    wb(8'h30, 0, 0, 32'hffffffff);
    $display("test reset done");
    // slow oscillator started well before the display is enabled
    wb(8'h04, 1, 32'h2, 0);
    wb(8'h04, 1, 32'h0, 0);
    st(2);
    chk(osc, 1'b1);
    f = {8'h0, $urandom | 32'h1};
    wb(8'h08, 1, f[31:0], 0);
    st(2);
    chk(fpo, 0);
    wb(8'h00, 1, 32'h80, 0);
    st(2);
    chk(fpo, f);
    chk(bpl, 8'h57);
    chk(fpl[1:0], 2'h2);
    v = $urandom;
    f[39:32] = v[7:0];
    wb(8'h0c, 1, v, 0);
    st(2);
    chk(fpo, f);
    $display("test enable done");
    for (i = 0; i < 8; i++) begin
      n = (i % 4 == 0) ? 4 : i % 4;
      wb(8'h00, 1, 32'h80 | i[2:0], 0);
      wb(8'h28, 0, (40 * n) << 8 | n << 4, 32'hff70);
      st(2);
      chk(bpo, (4'h1 << n) - 4'h1);
      chk(bias, n == 1 ? 2'h0 : (n == 2 && !i[2]) ? 2'h1 : 2'h2);
    end
    $display("test duty done");
    wb(8'h00, 1, 32'h80, 0);
    v = $urandom;
    wb(8'h10, 1, v, 0);
    wb(8'h10, 0, v, 32'hffffffff);
    acc = 4'h0;
    repeat (3000) begin
      @(posedge clk);
      tick <= 1'($urandom);
      acc = acc | seen;
    end
    chk(acc, v[3:0]);
    $display("test segments done");
    @(posedge clk) wt <= 1'b1;
    st(3);
    chk(|bpl, 1'b1);
    wb(8'h28, 0, 32'h10000, 32'h10008);
    wb(8'h04, 1, 32'h1, 0);
    st(2);
    chk({fpl, bpl, bpo, fpo}, {88'h0, 4'hf, f});
    wb(8'h28, 0, 32'h8, 32'h10008);
    @(posedge clk) wt <= 1'b0;
    wb(8'h10, 0, v, 32'hffffffff);
    wb(8'h04, 0, 32'h3, 32'h3);
    $display("test wait done");
    @(posedge clk) stp <= 1'b1;
    st(3);
    chk({fpl, bpl, bpo, fpo}, {88'h0, 4'hf, f});
    wb(8'h28, 0, 32'h8, 32'h10008);
    @(posedge clk) stp <= 1'b0;
    tick <= 1'b1;
    st(3);
    chk({|bpl, bpo, fpo}, {1'b1, 4'hf, f});
    wb(8'h28, 0, 32'h10000, 32'h10008);
    $display("test stop done");
    // source tick every cycle: each backplane step lasts exactly one divisor
    v = $urandom;
    wb(8'h00, 1, 32'h80 | v[5:4] << 4, 0);
    for (i = 0; i < 3; i++) begin
      n = 0;
      r[7:0] = bpl;
      do begin
        @(posedge clk);
        n++;
      end while (bpl === r[7:0] && n < 2000);
    end
    chk(n, 64 << v[5:4]);
    $display("test prescale done");
    give_verdict;
  end
endmodule
`default_nettype wire
